// ==== qfl_pkg.sv ====
// Shared constants and types for the queue flag status logic
package qfl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_QUEUES = 4;
  localparam int QSEL_W     = 2;
  localparam int DEVID_W    = 3;
  localparam int CNT_W      = 15;

  // ----------------------------------------------------------------
  // Reset and preset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] DEF_DEPTH     = 15'h1000;
  localparam logic [CNT_W-1:0] PRESET_SMALL  = 15'h0008;
  localparam logic [CNT_W-1:0] PRESET_LARGE  = 15'h0080;
  localparam logic [CNT_W-1:0] RST_OFFSET    = PRESET_SMALL;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int FLAG_PIPE_CYC  = 2;
  localparam int SEL_TO_FLAG_CYC = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEVID_W-1:0] devId;
    logic [QSEL_W-1:0]  queue;
  } qfl_qaddr_t;

  typedef struct packed {
    logic [QSEL_W-1:0] queue;
    logic [CNT_W-1:0]  depth;
    logic [CNT_W-1:0]  afOffset;
  } qfl_prog_t;

endpackage

// ==== qfl_queue_track.sv ====
// Per-queue fill level and almost-full tracking
`timescale 1ns/1ps

module qfl_queue_track #(
  parameter int CNT_W = 15
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             wrInc,
  input  wire logic             rdDec,
  input  wire logic [CNT_W-1:0] depth,
  input  wire logic [CNT_W-1:0] afOffset,
  output logic                  empty,
  output logic                  almostFullN
);

  logic [CNT_W-1:0] level_ff;
  logic [CNT_W-1:0] nxt_level;
  logic             doInc;
  logic             doDec;

  // Refuse overflow and underflow instead of wrapping
  assign doInc = wrInc && (level_ff < depth);
  assign doDec = rdDec && (level_ff != '0);

  always_comb begin
    nxt_level = level_ff;
    if (doInc && !doDec) begin
      nxt_level = level_ff + 1'b1;
    end else if (doDec && !doInc) begin
      nxt_level = level_ff - 1'b1;
    end
  end

  // Reads update the level even when not the active write queue
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_ff <= '0;
    end else begin
      level_ff <= nxt_level;  // R12
    end
  end

  assign empty       = (level_ff == '0);
  assign almostFullN = !(level_ff >= (depth - afOffset));  // R17

endmodule

// ==== qfl_flag_status.sv ====
// Active-queue output-valid and almost-full flag logic
// Operation
// R01: Output-valid pin floats when no own queue read
// R02: Top 3 read address bits match strap drive
// R03: Keep driving across switches within this device
// R04: Controller wires flags, reads one device only
// R05: Per-queue almost-full, output shows write queue
// R06: Per-queue offset programmable zero to depth
// R07: Default programming picks 8 or 128 offset
// R08: New write queue status on second edge
// R09: Almost-full low two cycles after crossing write
// R10: Read release after skew plus one cycle
// R11: Almost-full changes only on clock rising edge
// R12: Non-active queues update on reads too
// R13: Per-queue almost-full copy on four-bit bus
// R14: Output-valid low while output word valid
// R15: New read queue status two cycles later
// R16: Drive decision from address taken on enable
// R17: Almost-full low at depth minus offset words
`timescale 1ns/1ps

module qfl_flag_status #(
  parameter int NUM_QUEUES = qfl_pkg::NUM_QUEUES,
  parameter int CNT_W      = qfl_pkg::CNT_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  dev_strap_bit0,
  input  wire logic                  dev_strap_bit1,
  input  wire logic                  dev_strap_bit2,
  input  wire qfl_pkg::qfl_qaddr_t   wr_queue_sel,
  input  wire logic                  wr_sel_en,
  input  wire logic                  wrEn,
  input  wire qfl_pkg::qfl_qaddr_t   rd_queue_sel,
  input  wire logic                  rd_sel_en,
  input  wire logic                  rdEn,
  input  wire logic                  progLoad,
  input  wire qfl_pkg::qfl_prog_t    progData,
  input  wire logic                  defaultLoad,
  input  wire logic                  defaultLarge,
  output logic                       out_valid_n,
  output logic                       outValidOe,
  output logic                       almost_full_n,
  output logic [NUM_QUEUES-1:0]      almost_full_bus_n
);

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strapMeta_ff;
  logic [2:0] strapSync_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta_ff <= 3'h0;
      strapSync_ff <= 3'h0;
    end else begin
      strapMeta_ff <= {dev_strap_bit2, dev_strap_bit1, dev_strap_bit0};
      strapSync_ff <= strapMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Queue selection registers
  // ----------------------------------------------------------------
  logic [1:0] wrQueue_ff;
  logic       wrOwn_ff;
  logic [1:0] rdQueue_ff;
  logic       rdOwn_ff;
  logic       wrMatch;
  logic       rdMatch;

  assign wrMatch = (wr_queue_sel.devId == strapSync_ff);
  assign rdMatch = (rd_queue_sel.devId == strapSync_ff);  // R02

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrQueue_ff <= 2'h0;
      wrOwn_ff   <= 1'b0;
    end else if (wr_sel_en) begin
      wrQueue_ff <= wr_queue_sel.queue;  // R08
      wrOwn_ff   <= wrMatch;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdQueue_ff <= 2'h0;
      rdOwn_ff   <= 1'b0;
    end else if (rd_sel_en) begin
      rdQueue_ff <= rd_queue_sel.queue;  // R16
      rdOwn_ff   <= rdMatch;
    end
  end

  // ----------------------------------------------------------------
  // Per-queue programming
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] depth_ff  [NUM_QUEUES];
  logic [CNT_W-1:0] offset_ff [NUM_QUEUES];
  logic [CNT_W-1:0] presetOff;
  logic [CNT_W-1:0] progOff;

  assign presetOff = defaultLarge ? qfl_pkg::PRESET_LARGE
                                  : qfl_pkg::PRESET_SMALL;  // R07
  // An offset past the depth is clamped to the depth
  assign progOff = (progData.afOffset > progData.depth) ? progData.depth
                                                        : progData.afOffset;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        depth_ff[i]  <= qfl_pkg::DEF_DEPTH;
        offset_ff[i] <= qfl_pkg::RST_OFFSET;
      end
    end else if (defaultLoad) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        depth_ff[i]  <= qfl_pkg::DEF_DEPTH;
        offset_ff[i] <= presetOff;  // R07
      end
    end else if (progLoad) begin
      depth_ff[progData.queue]  <= progData.depth;
      offset_ff[progData.queue] <= progOff;  // R06
    end
  end

  // ----------------------------------------------------------------
  // Queue trackers
  // ----------------------------------------------------------------
  logic [NUM_QUEUES-1:0] qEmpty;
  logic [NUM_QUEUES-1:0] qAfN;

  // Writes and reads only touch this device's queues
  for (genvar g = 0; g < NUM_QUEUES; g++) begin : g_q
    qfl_queue_track #(
      .CNT_W(CNT_W)
    ) u_track (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .wrInc      (wrEn && wrOwn_ff && (wrQueue_ff == g)),
      .rdDec      (rdEn && rdOwn_ff && (rdQueue_ff == g)),
      .depth      (depth_ff[g]),
      .afOffset   (offset_ff[g]),
      .empty      (qEmpty[g]),
      .almostFullN(qAfN[g])
    );
  end

  // ----------------------------------------------------------------
  // Almost-full flag, two register stages
  // ----------------------------------------------------------------
  logic                  afStage_ff;
  logic                  afOut_ff;
  logic [NUM_QUEUES-1:0] afBusStage_ff;
  logic [NUM_QUEUES-1:0] afBusOut_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      afStage_ff <= 1'b1;
      afOut_ff   <= 1'b1;
    end else begin
      afStage_ff <= qAfN[wrQueue_ff];  // R05
      afOut_ff   <= afStage_ff;        // R09 R10 R11
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      afBusStage_ff <= '1;
      afBusOut_ff   <= '1;
    end else begin
      afBusStage_ff <= qAfN;          // R13
      afBusOut_ff   <= afBusStage_ff;
    end
  end

  assign almost_full_n     = afOut_ff;
  assign almost_full_bus_n = afBusOut_ff;

  // ----------------------------------------------------------------
  // Output-valid flag and its drive enable
  // ----------------------------------------------------------------
  logic ovStage_ff;
  logic ovOut_ff;
  logic oeStage_ff;
  logic oeOut_ff;

  // Status follows the data path: previous queue for one more cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovStage_ff <= 1'b1;
      ovOut_ff   <= 1'b1;
    end else begin
      ovStage_ff <= qEmpty[rdQueue_ff];  // R14
      ovOut_ff   <= ovStage_ff;          // R15
    end
  end

  // Drive tracks the own-device decision, aligned with the flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oeStage_ff <= 1'b0;
      oeOut_ff   <= 1'b0;
    end else begin
      oeStage_ff <= rdOwn_ff;    // R01 R03
      oeOut_ff   <= oeStage_ff;
    end
  end

  assign out_valid_n = ovOut_ff;
  assign outValidOe  = oeOut_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_oe_float;
    rd_sel_en && !rdMatch |-> ##3 !outValidOe;
  endproperty
  a_oe_float: assert property (p_oe_float)  // R01
    else $error("output-valid driven for foreign read select");

  property p_oe_match;
    rd_sel_en && rdMatch |=> ##2 outValidOe;
  endproperty
  a_oe_match: assert property (p_oe_match)  // R02
    else $error("output-valid not driven after own select");

  // Own-to-own switch: no gap in drive while the pipe turns over
  property p_oe_hold;
    rd_sel_en && rdMatch && rdOwn_ff |=> ##1 outValidOe [*2];
  endproperty
  a_oe_hold: assert property (p_oe_hold)  // R03
    else $error("output-valid released on in-device switch");

  property p_oe_follow;
    outValidOe == $past(rdOwn_ff, 2);
  endproperty
  a_oe_follow: assert property (p_oe_follow)  // R16
    else $error("drive enable not from registered select");

  property p_af_select;
    ##2 almost_full_n == $past(qAfN[wrQueue_ff], 2);
  endproperty
  a_af_select: assert property (p_af_select)  // R05
    else $error("almost-full not tracking write queue");

  property p_af_switch;
    wr_sel_en ##1 !wr_sel_en [*2] |=>
      almost_full_n == $past(qAfN[wrQueue_ff], 2);
  endproperty
  a_af_switch: assert property (p_af_switch)  // R08
    else $error("almost-full not on new queue by second edge");

  property p_af_fall;
    $fell(qAfN[wrQueue_ff]) && $stable(wrQueue_ff) |-> ##2 !almost_full_n;
  endproperty
  a_af_fall: assert property (p_af_fall)  // R09
    else $error("almost-full not low two cycles after crossing");

  property p_af_rise;
    $rose(qAfN[wrQueue_ff]) && $stable(wrQueue_ff) |-> ##2 almost_full_n;
  endproperty
  a_af_rise: assert property (p_af_rise)  // R10
    else $error("almost-full not released after read");

  property p_bus_copy;
    ##2 almost_full_bus_n == $past(qAfN, 2);
  endproperty
  a_bus_copy: assert property (p_bus_copy)  // R13
    else $error("almost-full bus not a delayed copy");

  property p_preset;
    defaultLoad && defaultLarge |=> offset_ff[0] == qfl_pkg::PRESET_LARGE;
  endproperty
  a_preset: assert property (p_preset)  // R07
    else $error("large preset offset not applied");

  property p_preset_small;
    defaultLoad && !defaultLarge |=>
      offset_ff[NUM_QUEUES-1] == qfl_pkg::PRESET_SMALL;
  endproperty
  a_preset_small: assert property (p_preset_small)  // R07
    else $error("small preset offset not applied");

  property p_prog_offset;
    progLoad && !defaultLoad && progData.queue == 2'h1 &&
      progData.afOffset <= progData.depth |=>
      offset_ff[1] == $past(progData.afOffset);
  endproperty
  a_prog_offset: assert property (p_prog_offset)  // R06
    else $error("programmed offset not held for its queue");

  property p_ov_pipe;
    ##2 out_valid_n == $past(qEmpty[rdQueue_ff], 2);
  endproperty
  a_ov_pipe: assert property (p_ov_pipe)  // R15
    else $error("output-valid not two cycles behind status");

  c_af_low: cover property (!almost_full_n);
  c_ov_valid: cover property (outValidOe && !out_valid_n);
  c_rd_switch: cover property (rd_sel_en && rdMatch ##1 rd_sel_en && rdMatch);
  c_af_release: cover property ($rose(almost_full_n));
  c_oe_float: cover property (rd_sel_en && !rdMatch);

endmodule

// ==== qfl_ctrl_model.sv ====
// Controller-side view of the shared output-valid line
`timescale 1ns/1ps

module qfl_ctrl_model (
  input  wire logic oe,
  input  wire logic ovN,
  output logic      lineN
);
  // Pull-up holds the wired line high while no device drives it
  assign lineN = oe ? ovN : 1'h1;
endmodule

// ==== test_queue_flag_status_logic.sv ====
// Self-checking bench for the queue flag status logic
`timescale 1ns/1ps

module test_queue_flag_status_logic;
  localparam logic [2:0] STRAP = 3'h5;
  logic                sys_clk = 1'h0;
  logic                resetn = 1'h0;
  logic                wrSelEn = 1'h0, wrEn = 1'h0, defLarge = 1'h0;
  logic                rdSelEn = 1'h0, rdEn = 1'h0;
  logic                progLoad = 1'h0, defLoad = 1'h0;
  logic                wGap = 1'h0, rGap = 1'h0;
  qfl_pkg::qfl_qaddr_t wSel = '0, rSel = '0;
  qfl_pkg::qfl_prog_t  prog = '0;
  logic                ovN, ovOe, afN, lineN;
  logic [3:0]          afBus, afS1, afS2;
  logic [14:0]         lvl[4], dep[4], off[4], d, o;
  logic [1:0]          wq, rq;
  logic                wOwn, rOwn, aS1, aS2, eS1, eS2, oS1, oS2;
  int                  err_count = 0, cmp_count = 0, quiet = 0;

  always #12.5 sys_clk = ~sys_clk;

  qfl_flag_status qfl_flag_status_i (
    .sys_clk(sys_clk), .resetn(resetn),
    .dev_strap_bit0(STRAP[0]), .dev_strap_bit1(STRAP[1]),
    .dev_strap_bit2(STRAP[2]), .wr_queue_sel(wSel),
    .wr_sel_en(wrSelEn), .wrEn(wrEn), .rd_queue_sel(rSel),
    .rd_sel_en(rdSelEn), .rdEn(rdEn), .progLoad(progLoad),
    .progData(prog), .defaultLoad(defLoad), .defaultLarge(defLarge),
    .out_valid_n(ovN), .outValidOe(ovOe), .almost_full_n(afN),
    .almost_full_bus_n(afBus));

  qfl_ctrl_model qfl_ctrl_model_i (.oe(ovOe), .ovN(ovN), .lineN(lineN));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic afOf(logic [1:0] q);
    return lvl[q] < dep[q] - off[q];
  endfunction

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int q = 0; q < 4; q++) begin
        lvl[q] = '0;
        dep[q] = 15'h1000;
        off[q] = 15'h0008;
      end
      {wq, rq, wOwn, rOwn} = 6'h0;
      {afS1, afS2} = 8'hff;
      {aS1, aS2, eS1, eS2, oS1, oS2} = 6'h3c;
    end else begin
      {afS2, aS2, eS2, oS2} = {afS1, aS1, eS1, oS1};
      for (int q = 0; q < 4; q++) afS1[q] = afOf(2'(q));
      {aS1, eS1, oS1} = {afOf(wq), lvl[rq] == '0, rOwn};
      if (wrEn && wOwn && lvl[wq] < dep[wq]) lvl[wq]++;
      if (rdEn && rOwn && lvl[rq] != '0) lvl[rq]--;
      if (wrSelEn) {wq, wOwn} = {wSel.queue, wSel.devId == STRAP};
      if (rdSelEn) {rq, rOwn} = {rSel.queue, rSel.devId == STRAP};
      if (defLoad) begin
        for (int q = 0; q < 4; q++) begin
          dep[q] = 15'h1000;
          off[q] = defLarge ? 15'h0080 : 15'h0008;
        end
      end else if (progLoad) begin
        dep[prog.queue] = prog.depth;
        off[prog.queue] = prog.afOffset;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk1(logic a, logic e);
    cmp_count++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t flag %b exp %b", $time, a, e);
    end
  endtask

  task automatic chk4(logic [3:0] a, logic [3:0] e);
    cmp_count++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t bus %h exp %h", $time, a, e);
    end
  endtask

  always @(negedge sys_clk) begin
    if (resetn) begin
      if (quiet > 0) quiet--;
      else begin
        chk1(afN, aS2);
        chk4(afBus, afS2);
      end
      chk1(ovOe, oS2);
      if (oS2) chk1(ovN, eS2);
      chk1(lineN, oS2 ? eS2 : 1'h1);
    end
  end

  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // No transfer on the select edge or the one after: data path not ready
  task automatic drv(logic [6:0] s, qfl_pkg::qfl_qaddr_t wa, ra,
                     qfl_pkg::qfl_prog_t pd);
    @(negedge sys_clk);
    if (s[5] || wGap) s[4] = 1'h0;
    if (s[3] || rGap) s[2] = 1'h0;
    if (s[4] && s[2] && wq == rq && (lvl[wq] == '0 || lvl[wq] == dep[wq]))
      s[2] = 1'h0;
    {wGap, rGap} = {s[5], s[3]};
    {defLarge, wrSelEn, wrEn, rdSelEn, rdEn, progLoad, defLoad} = s;
    wSel = wa;
    rSel = ra;
    prog = pd;
  endtask

  initial begin
    void'($urandom(75364));
    repeat (3) @(negedge sys_clk);
    resetn = 1'h1;
    repeat (3) drv(7'h0, wSel, rSel, prog);
    // Offset corners: zero and full depth
    for (int q = 0; q < 4; q++) begin
      d = 15'(16 + $urandom_range(0, 24));
      o = (q == 1) ? 15'h0 : (q == 2) ? d : 15'($urandom_range(0, d));
      quiet = 6;
      drv(7'h02, wSel, rSel, {2'(q), d, o});
    end
    repeat (3000)
      drv(7'($urandom_range(0, 127)) & 7'h3c,
          {STRAP, 2'($urandom_range(0, 3))},
          {$urandom_range(0, 2) == 0 ? 3'h2 : STRAP,
           2'($urandom_range(0, 3))}, prog);
    quiet = 6;
    drv(7'h41, wSel, rSel, prog);
    drv(7'h20, {STRAP, 2'h0}, rSel, prog);
    repeat (4100) drv(7'h10, wSel, rSel, prog);
    drv(7'h08, wSel, {STRAP, 2'h0}, prog);
    repeat (200) drv(7'h04, wSel, rSel, prog);
    quiet = 6;
    drv(7'h01, wSel, rSel, prog);
    repeat (200) drv(7'h10, wSel, rSel, prog);
    repeat (5) drv(7'h0, wSel, rSel, prog);
    end_of_test;
  end

  initial begin
    #(25 * 20000);
    err_count++;
    end_of_test;
  end
endmodule
